// ---- nco_alu.sv ----
// Combinational normalize and complement arithmetic
`timescale 1ns/1ps
module nco_alu
  import nco_pkg::*;
(
  // Operands and results
  nco_dp_if.unit dp
);

  function automatic logic ext_used(input logic [35:0] x);
    ext_used = !((&x[35:31]) || !(|x[35:31]));
  endfunction

  function automatic logic [15:0] bf_change(input logic [15:0] x, input logic [15:0] m);
    bf_change = x ^ m;
  endfunction

  logic        left;
  logic        right;
  logic        v;
  logic [35:0] sh;
  logic [15:0] opnd;
  logic [15:0] inv;

  always_comb begin
    dp.acc_res  = dp.acc;
    dp.word_res = dp.word;
    dp.sr_res   = dp.sr;
    dp.cnt_res  = dp.cnt;
    left  = !dp.sr[SR_E] && dp.sr[SR_U] && !dp.sr[SR_Z];
    right = dp.sr[SR_E];
    v     = 1'b0;
    sh    = dp.acc;
    opnd  = (dp.dst == DST_ACC) ? dp.acc[31:16] : dp.word;
    inv   = ~opnd;
    case (dp.op)
      OP_NORMALIZE_STEP: begin
        // [RL5] Flags select action
        if (left) begin
          // [RL1] Left shift, count down
          sh         = {dp.acc[34:0], 1'b0};
          dp.cnt_res = dp.cnt - 16'h0001;
        end else if (right) begin
          // [RL2] Right shift, count up
          sh         = {dp.acc[35], dp.acc[35:1]};
          dp.cnt_res = dp.cnt + 16'h0001;
        end
        // [RL6] Sign change on left shift
        v = left && (sh[35] != dp.acc[35]);
        dp.acc_res       = sh;
        dp.sr_res[SR_V]  = v;
        // [RL9] Limit stays if preset, or is set on overflow
        dp.sr_res[SR_L]  = dp.sr[SR_L] || v;
        // [RL8] Extension in use
        dp.sr_res[SR_E]  = ext_used(sh);
        dp.sr_res[SR_U]  = (sh[31] == sh[30]);
        // [RL7] Sign and zero
        dp.sr_res[SR_N]  = sh[35];
        dp.sr_res[SR_Z]  = (sh == 36'h0_0000_0000);
      end
      OP_NOT: begin
        // [RL12] Invert word or upper accumulator word
        if (dp.dst == DST_ACC) begin
          dp.acc_res[31:16] = inv;
        end else begin
          dp.word_res = inv;
        end
        // [RL14] Flags after complement
        dp.sr_res[SR_N] = inv[15];
        dp.sr_res[SR_Z] = (inv == 16'h0000);
        dp.sr_res[SR_V] = 1'b0;
      end
      OP_COMPLEMENT_WITH_CARRY_OP: begin
        // [RL15] Bit-field change with full mask
        if (dp.dst == DST_SR) begin
          // [RL18] Status follows the field
          dp.sr_res = bf_change(dp.sr, MASK_ALL);
        end else begin
          // [RL19] Only upper accumulator word
          if (dp.dst == DST_ACC) begin
            dp.acc_res[31:16] = bf_change(opnd, MASK_ALL);
          end else begin
            dp.word_res = bf_change(opnd, MASK_ALL);
          end
          // [RL16] Carry when all ones
          dp.sr_res[SR_C] = ((opnd & MASK_ALL) == MASK_ALL);
          // [RL17] Limit from source move
          dp.sr_res[SR_L] = dp.sr[SR_L] || dp.src_lim;
        end
      end
      default: begin
      end
    endcase
  end

endmodule // nco_alu

// ---- nco_core.sv ----
// Normalize and complement unit with APB register access
// Summary of operation
// [RL1] Extension free, unnormalized, nonzero: shift left once, count down.
// [RL2] Extension in use: shift right once arithmetically, count up.
// [RL3] Normalized or zero: accumulator and count stay unchanged.
// [RL4] Normalize works on all 36 bits and writes back there.
// [RL5] Action comes from stored extension, unnormalized and zero flags.
// [RL6] Overflow set when bit 35 changes on a left shift.
// [RL7] Negative follows bit 35; zero set on zero result.
// [RL8] Limit follows overflow; extension flag follows result extension.
// [RL9] Limit and overflow end cleared unless preset wrongly.
// [RL10] Normalize takes only the count register and an accumulator.
// [RL11] Normalize and plain complement take two cycles.
// [RL12] Plain complement inverts a word or accumulator bits 31 to 16.
// [RL13] Saturation setting never touches the complement result.
// [RL14] Complement flags: negative from top bit, zero, overflow cleared.
// [RL15] Complement with carry is a bit-field change with all-ones mask.
// [RL16] Carry set when the operand was all ones beforehand.
// [RL17] Limit set when the 36-bit source move was limited.
// [RL18] Status destination changes exactly as the inverted field.
// [RL19] Accumulator destination: only bits 31 to 16 invert.
// [RL20] Count register wraps in 16-bit two's complement.
`timescale 1ns/1ps
module nco_core
  import nco_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Status
  output logic             op_busy
);

  function automatic logic mapped(input logic [11:0] a);
    case (a)
      OFS_CMD, OFS_ACCA_LO, OFS_ACCA_HI, OFS_ACCB_LO, OFS_ACCB_HI,
      OFS_SHCNT, OFS_REG16, OFS_STATUS, OFS_STATE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  function automatic logic cmd_legal(input logic [31:0] w);
    nco_op_t  o;
    nco_dst_t d;
    o = nco_op_t'(w[CMD_OP_LSB +: 2]);
    d = nco_dst_t'(w[CMD_DST_LSB +: 2]);
    case (o)
      OP_NORMALIZE_STEP: cmd_legal = (d == DST_ACC);
      OP_NOT:  cmd_legal = (d == DST_ACC) || (d == DST_REG);
      OP_COMPLEMENT_WITH_CARRY_OP: cmd_legal = (d != DST_BAD);
      default: cmd_legal = 1'b0;
    endcase
  endfunction

  nco_dp_if dp ();

  logic [35:0] acc_a_r;
  logic [35:0] acc_b_r;
  logic [15:0] shcnt_r;
  logic [15:0] reg16_r;
  logic [15:0] sr_r;
  nco_op_t     op_r;
  nco_dst_t    dst_r;
  logic        sel_r;
  logic        lim_r;
  logic        sat_r;
  nco_state_t  state_r;
  logic [1:0]  cnt_r;
  logic        busy_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;
  logic        access;
  logic        wr_en;
  logic        start;
  logic        commit;
  logic [35:0] acc_cur;

  assign access  = psel && penable;
  assign wr_en   = access && pready_r && pwrite && !pslverr_r;
  assign start   = wr_en && (paddr == OFS_CMD);
  assign commit  = (state_r == ST_RUN) && (cnt_r == 2'h0);
  assign acc_cur = sel_r ? acc_b_r : acc_a_r;

  // Operands to the arithmetic unit
  assign dp.op      = op_r;
  assign dp.dst     = dst_r;
  assign dp.src_lim = lim_r;
  assign dp.acc     = acc_cur;
  assign dp.word    = reg16_r;
  assign dp.sr      = sr_r;
  assign dp.cnt     = shcnt_r;

  nco_alu u_alu (
    .dp (dp)
  );

  // One wait state per access, longer while an operation runs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r <= access && !pready_r && !busy_r;
      if (access && !pready_r && !busy_r) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
        // [RL10] Illegal operand pairing refused
        pslverr_r <= !mapped(paddr) || (pwrite && paddr == OFS_CMD && !cmd_legal(pwdata));
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  always_comb begin
    case (paddr)
      OFS_CMD:     rd_nxt = {18'h0, sat_r, lim_r, 2'h0, dst_r, 3'h0, sel_r, 2'h0, op_r};
      OFS_ACCA_LO: rd_nxt = acc_a_r[31:0];
      OFS_ACCA_HI: rd_nxt = {28'h000_0000, acc_a_r[35:32]};
      OFS_ACCB_LO: rd_nxt = acc_b_r[31:0];
      OFS_ACCB_HI: rd_nxt = {28'h000_0000, acc_b_r[35:32]};
      OFS_SHCNT:   rd_nxt = {16'h0000, shcnt_r};
      OFS_REG16:   rd_nxt = {16'h0000, reg16_r};
      OFS_STATUS:  rd_nxt = {16'h0000, sr_r};
      OFS_STATE:   rd_nxt = {31'h0000_0000, busy_r};
      default:     rd_nxt = 32'h0000_0000;
    endcase
  end

  // Command latch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_r  <= OP_NONE;
      dst_r <= DST_ACC;
      sel_r <= 1'b0;
      lim_r <= 1'b0;
      sat_r <= 1'b0;
    end else if (start) begin
      op_r  <= nco_op_t'(pwdata[CMD_OP_LSB +: 2]);
      dst_r <= nco_dst_t'(pwdata[CMD_DST_LSB +: 2]);
      sel_r <= pwdata[CMD_ACC_SEL];
      lim_r <= pwdata[CMD_SRC_LIM];
      // [RL13] Saturation kept but unused by complement
      sat_r <= pwdata[CMD_SAT_EN];
    end
  end

  // Sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      cnt_r   <= 2'h0;
      busy_r  <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_RUN;
            busy_r  <= 1'b1;
            // [RL11] Two-cycle execution, four cycles for complement with carry
            case (nco_op_t'(pwdata[CMD_OP_LSB +: 2]))
              OP_COMPLEMENT_WITH_CARRY_OP: cnt_r <= 2'(COMPLEMENT_WITH_CARRY_OP_CYC - 3'h1);
              OP_NOT:  cnt_r <= NOT_CYC - 2'h1;
              default: cnt_r <= NORMALIZE_STEP_CYC - 2'h1;
            endcase
          end
        end
        ST_RUN: begin
          if (cnt_r == 2'h0) begin
            state_r <= ST_IDLE;
            busy_r  <= 1'b0;
          end else begin
            cnt_r <= cnt_r - 2'h1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end

  // Accumulators
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_a_r <= RST_ACC;
      acc_b_r <= RST_ACC;
    end else if (commit && dst_r == DST_ACC) begin
      // [RL4] Full-width write back
      if (sel_r) begin
        acc_b_r <= dp.acc_res;
      end else begin
        acc_a_r <= dp.acc_res;
      end
    end else if (wr_en) begin
      case (paddr)
        OFS_ACCA_LO: acc_a_r[31:0]  <= pwdata;
        OFS_ACCA_HI: acc_a_r[35:32] <= pwdata[3:0];
        OFS_ACCB_LO: acc_b_r[31:0]  <= pwdata;
        OFS_ACCB_HI: acc_b_r[35:32] <= pwdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // Shift count, word register and status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shcnt_r <= RST_WORD;
      reg16_r <= RST_WORD;
      sr_r    <= RST_SR;
    end else if (commit) begin
      // [RL20] Count wraps in 16 bits
      shcnt_r <= dp.cnt_res;
      reg16_r <= dp.word_res;
      sr_r    <= dp.sr_res;
    end else if (wr_en) begin
      case (paddr)
        OFS_SHCNT:  shcnt_r <= pwdata[15:0];
        OFS_REG16:  reg16_r <= pwdata[15:0];
        OFS_STATUS: sr_r    <= pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign op_busy = busy_r;

  // Helpers for the checks
  logic        do_normalize_step;
  logic        normalize_step_left;
  logic        normalize_step_right;
  logic        acc_msb;
  logic [35:0] acc_shl;
  logic [35:0] acc_shr;
  logic [35:0] acc_inv;
  logic [15:0] cnt_dec;
  logic [15:0] cnt_inc;
  logic [15:0] opnd16;

  assign do_normalize_step    = commit && op_r == OP_NORMALIZE_STEP;
  assign normalize_step_left  = !sr_r[SR_E] && sr_r[SR_U] && !sr_r[SR_Z];
  assign normalize_step_right = sr_r[SR_E];
  assign acc_msb    = acc_cur[35];
  assign acc_shl    = {acc_cur[34:0], 1'b0};
  assign acc_shr    = {acc_cur[35], acc_cur[35:1]};
  assign acc_inv    = {acc_cur[35:32], ~acc_cur[31:16], acc_cur[15:0]};
  assign cnt_dec    = shcnt_r - 16'h0001;
  assign cnt_inc    = shcnt_r + 16'h0001;
  assign opnd16     = (dst_r == DST_ACC) ? acc_cur[31:16] : reg16_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  normalize_step_left_a: assert property (do_normalize_step && normalize_step_left |=> // [RL1]
    acc_cur == $past(acc_shl) && shcnt_r == $past(cnt_dec))
    else $error("normalize left step wrong");

  normalize_step_right_a: assert property (do_normalize_step && normalize_step_right |=> // [RL2]
    acc_cur == $past(acc_shr) && shcnt_r == $past(cnt_inc))
    else $error("normalize right step wrong");

  normalize_step_hold_a: assert property (do_normalize_step && !normalize_step_left && !normalize_step_right |=> // [RL3]
    $stable(acc_cur) && $stable(shcnt_r))
    else $error("normalize no-op changed state");

  ovf_flag_a: assert property (do_normalize_step |=> // [RL6]
    sr_r[SR_V] == (acc_msb != $past(acc_msb)))
    else $error("overflow flag mismatch");

  sign_zero_a: assert property (do_normalize_step |=> // [RL7]
    sr_r[SR_N] == acc_msb && sr_r[SR_Z] == (acc_cur == 36'h0_0000_0000))
    else $error("sign or zero flag mismatch");

  op_time_a: assert property (start && pwdata[CMD_OP_LSB +: 2] != OP_COMPLEMENT_WITH_CARRY_OP |=> // [RL11]
    busy_r [*2] ##1 !busy_r)
    else $error("operation length wrong");

  not_acc_a: assert property (commit && op_r == OP_NOT && dst_r == DST_ACC |=> // [RL12]
    acc_cur == $past(acc_inv) && !sr_r[SR_V])
    else $error("complement of accumulator wrong");

  carry_test_a: assert property (commit && op_r == OP_COMPLEMENT_WITH_CARRY_OP && dst_r != DST_SR |=> // [RL16]
    sr_r[SR_C] == ($past(opnd16) == 16'hFFFF))
    else $error("carry test wrong");

  sr_change_a: assert property (commit && op_r == OP_COMPLEMENT_WITH_CARRY_OP && dst_r == DST_SR |=> // [RL18]
    sr_r == ~$past(sr_r))
    else $error("status change wrong");

  complement_with_carry_op_acc_a: assert property (commit && op_r == OP_COMPLEMENT_WITH_CARRY_OP && dst_r == DST_ACC |=> // [RL19]
    acc_cur == $past(acc_inv))
    else $error("accumulator field change wrong");

  normalize_step_limit_a: assert property (do_normalize_step |=> // [RL9]
    sr_r[SR_L] == ($past(sr_r[SR_L]) || sr_r[SR_V]))
    else $error("limit flag not sticky on overflow");

  ext_flag_a: assert property (do_normalize_step |=> // [RL8]
    sr_r[SR_E] == (acc_cur[35:31] != 5'h00 && acc_cur[35:31] != 5'h1F))
    else $error("extension flag mismatch");

  normalize_step_wrap_a: assert property (do_normalize_step && normalize_step_left && shcnt_r == 16'h0000 |=> // [RL20]
    shcnt_r == 16'hFFFF)
    else $error("shift count did not wrap");

  not_flags_a: assert property (commit && op_r == OP_NOT |=> // [RL14]
    sr_r[SR_N] == opnd16[15] && sr_r[SR_Z] == (opnd16 == 16'h0000) && !sr_r[SR_V])
    else $error("complement flags wrong");

  not_reg_a: assert property (commit && op_r == OP_NOT && dst_r == DST_REG |=> // [RL12]
    reg16_r == ~$past(reg16_r))
    else $error("complement of word register wrong");

  complement_with_carry_op_limit_a: assert property (commit && op_r == OP_COMPLEMENT_WITH_CARRY_OP && dst_r != DST_SR |=> // [RL17]
    sr_r[SR_L] == ($past(sr_r[SR_L]) || lim_r))
    else $error("limit after source move wrong");

  complement_with_carry_op_time_a: assert property (start && pwdata[CMD_OP_LSB +: 2] == OP_COMPLEMENT_WITH_CARRY_OP |=> // [RL11]
    busy_r [*4] ##1 !busy_r)
    else $error("complement with carry length wrong");

  cover_normalize_step_left_c:  cover property (do_normalize_step && normalize_step_left);
  cover_normalize_step_right_c: cover property (do_normalize_step && normalize_step_right);
  cover_complement_with_carry_op_sr_c:    cover property (commit && op_r == OP_COMPLEMENT_WITH_CARRY_OP && dst_r == DST_SR);
  cover_refused_c:    cover property (pready_r && pslverr_r);
  cover_carry_set_c:  cover property (commit && op_r == OP_COMPLEMENT_WITH_CARRY_OP && dst_r != DST_SR && opnd16 == 16'hFFFF);

endmodule // nco_core

// ---- nco_core_tb.sv ----
// Self-checking bench of the normalize and complement unit
`timescale 1ns/1ps
module nco_core_tb;
  import nco_pkg::*;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, op_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [35:0] m_acc [2];
  logic [15:0] m_cnt, m_reg, m_sr;
  int          failures, n_checks;
  localparam logic [15:0] SRM = 16'h83FF;
  localparam logic [31:0] BAD [5] = '{32'h0000_0000, 32'h0000_0101, 32'h0000_0201, 32'h0000_0202, 32'h0000_0303};

  nco_core u_nco_core (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_busy(op_busy));
  nco_seq_model u_seq (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic eerr,
                     output logic [31:0] q);
    logic e;
    u_seq.xfer(w, a, d, $urandom_range(0, 1), q, e);
    chk(e, eerr, "slave error flag");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 1'b0, q);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 1'b0, q);
    chk(q, e, what);
  endtask

  task automatic cmp_all;
    logic [31:0] q;
    rdc(OFS_ACCA_LO, m_acc[0][31:0], "acc A low");
    rdc(OFS_ACCA_HI, {28'h0000000, m_acc[0][35:32]}, "acc A high");
    rdc(OFS_ACCB_LO, m_acc[1][31:0], "acc B low");
    rdc(OFS_ACCB_HI, {28'h0000000, m_acc[1][35:32]}, "acc B high");
    rdc(OFS_SHCNT, {16'h0000, m_cnt}, "shift count");
    rdc(OFS_REG16, {16'h0000, m_reg}, "word register");
    bus(1'b0, OFS_STATUS, 32'h0000_0000, 1'b0, q);
    chk(q & {16'h0000, SRM}, {16'h0000, m_sr & SRM}, "status");
  endtask

  task automatic set_acc(input int s, input logic [35:0] v);
    m_acc[s] = v;
    wr(s ? OFS_ACCB_LO : OFS_ACCA_LO, v[31:0]);
    wr(s ? OFS_ACCB_HI : OFS_ACCA_HI, {28'h0000000, v[35:32]});
  endtask

  task automatic preset(input int s, input logic badl);
    logic [35:0] a;
    a = m_acc[s];
    m_sr[SR_E] = !(a[35:31] == 5'h00 || a[35:31] == 5'h1F);
    m_sr[SR_U] = a[31] == a[30];
    m_sr[SR_Z] = a == 36'h0_0000_0000;
    m_sr[SR_L] = badl;
    m_sr[SR_V] = 1'b0;
    wr(OFS_STATUS, {16'h0000, m_sr});
  endtask

  task automatic op(input logic [1:0] o, input int s, input logic [1:0] d, input logic lim);
    logic [15:0] f;
    logic [35:0] a, x;
    logic        v, sat;
    int          n;
    logic [31:0] c;
    a = m_acc[s];
    sat = 1'($urandom_range(0, 1));
    c = {18'h00000, sat, lim, 2'h0, d, 3'h0, 1'(s), 2'h0, o};
    wr(OFS_CMD, c);
    n = 0;
    repeat (8) begin
      @(posedge clk);
      if (op_busy === 1'b1) n++;
    end
    chk(n, (o == 2'h3) ? 4 : 2, "busy length");
    if (o == 2'h1) begin
      v = 1'b0;
      if (!m_sr[SR_E] && m_sr[SR_U] && !m_sr[SR_Z]) begin
        x = a << 1;
        v = x[35] ^ a[35];
        m_cnt--;
      end else if (m_sr[SR_E]) begin
        x = {a[35], a[35:1]};
        m_cnt++;
      end else x = a;
      m_acc[s] = x;
      m_sr[SR_V] = v;
      m_sr[SR_L] = m_sr[SR_L] | v;
      m_sr[SR_N] = x[35];
      m_sr[SR_Z] = x == 36'h0_0000_0000;
      m_sr[SR_E] = !(x[35:31] == 5'h00 || x[35:31] == 5'h1F);
      m_sr[SR_U] = x[31] == x[30];
    end else if (d == 2'h2) begin
      m_sr = ~m_sr;
    end else begin
      f = (d == 2'h0) ? a[31:16] : m_reg;
      if (d == 2'h0) m_acc[s][31:16] = ~f;
      else m_reg = ~f;
      if (o == 2'h2) begin
        m_sr[SR_N] = ~f[15];
        m_sr[SR_Z] = f == 16'hFFFF;
        m_sr[SR_V] = 1'b0;
      end else begin
        m_sr[SR_C] = f == 16'hFFFF;
        m_sr[SR_L] = m_sr[SR_L] | lim;
      end
    end
    cmp_all;
    rdc(OFS_CMD, c, "command word");
  endtask

  task automatic finish_test;
    $display("Checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Whole run needs some 3600 cycles; allow over sixteen times that
  initial begin
    #240000;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test;
  end

  initial begin
    logic [1:0]  o, d;
    logic [35:0] a;
    int          s;
    rst_b = 1'b0;
    failures = 0;
    n_checks = 0;
    m_acc[0] = 36'h0_0000_0000;
    m_acc[1] = 36'h0_0000_0000;
    m_cnt = 16'h0000;
    m_reg = 16'h0000;
    m_sr = 16'h0000;
    void'($urandom(32'h45e6));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    cmp_all;
    $display("Test reset values done");
    set_acc(0, 36'h0_0000_8000);
    preset(0, 1'b0);
    repeat (31) op(2'h1, 0, 2'h0, 1'b0);
    chk(m_acc[0], 36'h0_4000_0000, "left run result");
    chk(m_cnt, 16'hFFF1, "left run count");
    $display("Test left normalize done");
    set_acc(1, 36'h7_8000_0000);
    preset(1, 1'b1);
    repeat (3) op(2'h1, 1, 2'h0, 1'b0);
    $display("Test right normalize done");
    for (int k = 0; k < 5; k++) op((k < 2) ? 2'h2 : 2'h3, 0, 2'((k < 2) ? k : k - 2), 1'b1);
    $display("Test complement modes done");
    for (int i = 0; i < 24; i++) begin
      o = 2'($urandom_range(1, 3));
      s = $urandom_range(0, 1);
      d = (o == 2'h1) ? 2'h0 : 2'($urandom_range(0, (o == 2'h3) ? 2 : 1));
      a = 36'({$urandom, $urandom});
      if ($urandom_range(0, 2) == 0) a[31:16] = 16'hFFFF;
      set_acc(s, a);
      m_reg = ($urandom_range(0, 2) == 0) ? 16'hFFFF : 16'($urandom);
      wr(OFS_REG16, {16'h0000, m_reg});
      if (o == 2'h1) preset(s, 1'($urandom_range(0, 1)));
      op(o, s, d, 1'($urandom_range(0, 1)));
    end
    $display("Test random operations done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    m_acc = '{default: 36'h0_0000_0000};
    m_cnt = 16'h0000;
    m_reg = 16'h0000;
    m_sr = 16'h0000;
    cmp_all;
    $display("Test mid-run reset done");
    bus(1'b0, 12'h024, 32'h0000_0000, 1'b1, r);
    chk(r, 32'h0000_0000, "unmapped read data");
    bus(1'b1, 12'hFFC, 32'hFFFF_FFFF, 1'b1, r);
    foreach (BAD[k]) begin
      bus(1'b1, OFS_CMD, BAD[k], 1'b1, r);
      repeat (3) @(posedge clk);
      chk(op_busy, 1'b0, "refused command started");
    end
    rdc(OFS_STATE, 32'h0000_0000, "idle state");
    cmp_all;
    $display("Test refusals done");
    finish_test;
  end
endmodule // nco_core_tb

// ---- nco_dp_if.sv ----
// Operand and result bundle between the sequencer and the arithmetic unit
`timescale 1ns/1ps
interface nco_dp_if;
  import nco_pkg::*;
  nco_op_t     op;
  nco_dst_t    dst;
  logic        src_lim;
  logic [35:0] acc;
  logic [15:0] word;
  logic [15:0] sr;
  logic [15:0] cnt;
  logic [35:0] acc_res;
  logic [15:0] word_res;
  logic [15:0] sr_res;
  logic [15:0] cnt_res;
  modport core (output op, dst, src_lim, acc, word, sr, cnt, input acc_res, word_res, sr_res, cnt_res);
  modport unit (input op, dst, src_lim, acc, word, sr, cnt, output acc_res, word_res, sr_res, cnt_res);
endinterface : nco_dp_if

// ---- nco_pkg.sv ----
// Constants, register map and types of the normalize and complement unit
package nco_pkg;

  // Datapath widths
  localparam int unsigned ACC_W  = 36;
  localparam int unsigned WORD_W = 16;

  // Register byte offsets on the APB
  localparam logic [11:0] OFS_CMD     = 12'h000;
  localparam logic [11:0] OFS_ACCA_LO = 12'h004;
  localparam logic [11:0] OFS_ACCA_HI = 12'h008;
  localparam logic [11:0] OFS_ACCB_LO = 12'h00C;
  localparam logic [11:0] OFS_ACCB_HI = 12'h010;
  localparam logic [11:0] OFS_SHCNT   = 12'h014;
  localparam logic [11:0] OFS_REG16   = 12'h018;
  localparam logic [11:0] OFS_STATUS  = 12'h01C;
  localparam logic [11:0] OFS_STATE   = 12'h020;

  // Command word fields
  localparam int unsigned CMD_OP_LSB  = 0;
  localparam int unsigned CMD_ACC_SEL = 4;
  localparam int unsigned CMD_DST_LSB = 8;
  localparam int unsigned CMD_SRC_LIM = 12;
  localparam int unsigned CMD_SAT_EN  = 13;

  // Status register bit positions (mode upper byte, condition lower byte)
  localparam int unsigned SR_LF = 15;
  localparam int unsigned SR_I1 = 9;
  localparam int unsigned SR_I0 = 8;
  localparam int unsigned SR_SZ = 7;
  localparam int unsigned SR_L  = 6;
  localparam int unsigned SR_E  = 5;
  localparam int unsigned SR_U  = 4;
  localparam int unsigned SR_N  = 3;
  localparam int unsigned SR_Z  = 2;
  localparam int unsigned SR_V  = 1;
  localparam int unsigned SR_C  = 0;

  // Values after reset
  localparam logic [35:0] RST_ACC   = 36'h0_0000_0000;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [15:0] RST_SR    = 16'h0000;

  // Bit-field change mask used by the complement with carry
  localparam logic [15:0] MASK_ALL  = 16'hFFFF;

  // Execution lengths in clock cycles
  localparam logic [1:0] NORMALIZE_STEP_CYC = 2'h2;
  localparam logic [1:0] NOT_CYC  = 2'h2;
  localparam logic [2:0] COMPLEMENT_WITH_CARRY_OP_CYC = 3'h4;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_NORMALIZE_STEP = 2'b01,
    OP_NOT  = 2'b10,
    OP_COMPLEMENT_WITH_CARRY_OP = 2'b11
  } nco_op_t;

  typedef enum logic [1:0] {
    DST_ACC = 2'b00,
    DST_REG = 2'b01,
    DST_SR  = 2'b10,
    DST_BAD = 2'b11
  } nco_dst_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } nco_state_t;

endpackage : nco_pkg

// ---- nco_seq_model.sv ----
// APB sequencer model that issues register transfers to the unit
`timescale 1ns/1ps
module nco_seq_model (
  // Clock
  input  wire logic        clk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // One transfer after some idle cycles, held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input int idle, output logic [31:0] r, output logic err);
    repeat (idle) @(posedge clk);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    // Released lines carry inverted values so stale data is never trusted
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= ~w;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // nco_seq_model
